// File: rtl/rtcs_pkg.sv
/*
 Shared constants and types for the real-time clock control block:
 register locations, field positions, reset values and timing counts.
 Assumes a 100 MHz core clock.
*/
package rtcs_pkg;
	// ==========================================
	// Register locations (address byte bits 5..0)
	localparam logic [7:0] OFF_EVENT_FLAGS = 8'h30;
	localparam logic [7:0] OFF_TIMEBASE_CONTROL = 8'h31;
	localparam logic [7:0] OFF_IRQ_CONTROL = 8'h32;
	// ==========================================
	// Address/control byte fields
	localparam int ACB_WRITE = 7;
	localparam int ACB_CLK = 5;
	// ==========================================
	// Event flag positions
	localparam int EVF_WDOG = 6;
	localparam int EVF_TEST = 5;
	localparam int EVF_FTU = 4;
	localparam int EVF_INT = 3;
	localparam int EVF_PSENSE = 2;
	localparam int EVF_ALARM = 1;
	localparam int EVF_PERIOD = 0;
	// ==========================================
	// Reset values and codes
	localparam logic [7:0] TBC_RST = 8'h00;
	localparam logic [7:0] IRQC_RST = 8'h00;
	localparam logic [2:0] SQW_OFF = 3'h4;
	localparam logic [3:0] PER_OFF = 4'h0;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	// ==========================================
	// Timing
	localparam int CORE_PERIOD_NS = 10;
	localparam int WDOG_TIMEOUT_MS = 10;
	localparam int WDOG_CYC = WDOG_TIMEOUT_MS * 1000000 / CORE_PERIOD_NS;
	localparam int HRST_NS = 1000;
	localparam int HRST_CYC = (HRST_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	// ==========================================
	// Types
	typedef struct packed {
		logic run;
		logic line;
		logic [1:0] xsel;
		logic hz50;
		logic [2:0] sqw;
	} rtcs_tbc_t;
	typedef struct packed {
		logic wdog;
		logic pdown;
		logic psense;
		logic alarm;
		logic [3:0] per;
	} rtcs_irqc_t;
	typedef struct packed {
		logic write;
		logic is_addr;
		logic [5:0] loc;
		logic [7:0] data;
	} rtcs_ev_t;
endpackage : rtcs_pkg

// File: rtl/rtcs_spi_link.sv
/*
 Serial slave port on the host's serial clock: address/control byte,
 data bytes, read shifting and byte events toward the core.
 Assumes the core answers a location within half a serial clock period.
*/
`timescale 1ns/1ns
`default_nettype none
module rtcs_spi_link (
	// Reset
	input wire logic rst_n,
	// Link pins
	input wire logic sck_in,
	input wire logic ce_in,
	input wire logic mosi_in,
	output logic miso_o,
	output logic miso_oe,
	// Core side
	input wire logic pd_i,
	input wire logic [7:0] rd_data_i,
	output rtcs_pkg::rtcs_ev_t ev_o,
	output logic ev_tgl_o,
	output logic rdc_tgl_o
);
	import rtcs_pkg::*;

	// ==========================================
	// Polarity and link clock
	logic pol_q;
	logic [2:0] cnt_q;
	logic first_q;
	logic wr_q;
	logic [5:0] loc_q;
	logic [6:0] ish_q;
	logic [6:0] osh_q;
	wire link_clk = sck_in ^ pol_q;
	wire lrst_n = rst_n & ce_in & ~pd_i;
	wire [7:0] byte_w = {ish_q, mosi_in};
	wire last_w = (cnt_q == 3'h7);
	wire launch_w = (cnt_q == 3'h0) & ~first_q & ~wr_q;

	// Idle level tracked while disabled, frozen as chip enable rises;
	// a flop here would flip the link clock and fake a sampling edge
	always_latch
	begin
		if (!ce_in)
			pol_q <= sck_in;
	end

	// ==========================================
	// Sampling edge: back toward idle
	always_ff @(negedge link_clk or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			cnt_q <= 3'h0;
			first_q <= 1'b1;
			wr_q <= 1'b0;
			loc_q <= 6'h00;
			ish_q <= 7'h00;
		end
		else
		begin
			cnt_q <= cnt_q + 3'h1;
			ish_q <= byte_w[6:0];
			if (last_w && first_q)
			begin
				first_q <= 1'b0;
				wr_q <= byte_w[ACB_WRITE];
				loc_q <= byte_w[5:0];
			end
			else if (last_w)
				loc_q <= {loc_q[5], loc_q[4:0] + 5'h01};
		end
	end

	// Byte events survive chip enable, so toggles never glitch
	always_ff @(negedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ev_o <= '0;
			ev_tgl_o <= 1'b0;
		end
		else if (last_w)
		begin
			ev_o.write <= first_q ? byte_w[ACB_WRITE] : wr_q;
			ev_o.is_addr <= first_q;
			ev_o.loc <= first_q ? byte_w[5:0] : loc_q;
			ev_o.data <= byte_w;
			ev_tgl_o <= ~ev_tgl_o;
		end
	end

	// ==========================================
	// Launch edge: away from idle
	always_ff @(posedge link_clk or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			miso_o <= 1'b0;
			miso_oe <= 1'b0;
			osh_q <= 7'h00;
		end
		else if (launch_w)
		begin
			miso_o <= rd_data_i[7];
			osh_q <= rd_data_i[6:0];
			miso_oe <= 1'b1;
		end
		else
		begin
			miso_o <= osh_q[6];
			osh_q <= {osh_q[5:0], 1'b0};
		end
	end

	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdc_tgl_o <= 1'b0;
		else if (launch_w && lrst_n)
			rdc_tgl_o <= ~rdc_tgl_o;
	end
endmodule : rtcs_spi_link
`default_nettype wire

// File: rtl/rtcs_core.sv
/*
 Control, interrupt and status logic of a serial real-time clock,
 with its serial slave port instantiated on the host's serial clock.
 Assumes time-base ticks and the alarm compare come from same-clock logic.
*/
`timescale 1ns/1ns
`default_nettype none
module rtcs_core #(
	parameter int WDOG_CYCLES = rtcs_pkg::WDOG_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Serial port pins
	input wire logic sck_in,
	input wire logic ce_in,
	input wire logic mosi_in,
	output logic miso_o,
	output logic miso_oe,
	// Time base
	input wire logic [15:1] rate_tick_in,
	input wire logic alarm_match_in,
	input wire logic line_fail_in,
	input wire logic [7:0] sqw_src_in,
	output rtcs_pkg::rtcs_tbc_t tbc_o,
	// System control pins
	output logic sqw_out,
	output logic supply_enable_out,
	output logic host_reset_out_n,
	output logic host_reset_oe,
	output logic irq_n,
	output logic irq_oe
);
	import rtcs_pkg::*;

	localparam int WDW = $clog2(WDOG_CYCLES + 1);
	localparam int HRW = $clog2(HRST_CYC + 1);

	// ==========================================
	// State
	rtcs_tbc_t tbc_q;
	rtcs_irqc_t irqc_q;
	rtcs_ev_t ev_q;
	rtcs_ev_t ev_link;
	logic [7:0] rd_q;
	logic [5:0] rd_loc_q;
	logic evv_q;
	logic ev_s1_q, ev_s2_q, ev_s3_q;
	logic rc_s1_q, rc_s2_q, rc_s3_q;
	logic ce_s1_q, ce_s2_q, ce_s3_q;
	logic lf_s1_q, lf_s2_q, lf_s3_q;
	logic link_ev_tgl, link_rdc_tgl;
	logic st_wd_q, st_ftu_q, st_int_q, st_ps_q, st_al_q, st_per_q;
	logic irq_pend_q;
	logic ps_armed_q;
	logic al_prev_q;
	logic pd_q;
	logic [WDW-1:0] wd_cnt_q;
	logic [HRW-1:0] hrst_cnt_q;

	// ==========================================
	// Serial port on the link clock
	rtcs_spi_link u_link (
		.rst_n(rst_n),
		.sck_in(sck_in),
		.ce_in(ce_in),
		.mosi_in(mosi_in),
		.miso_o(miso_o),
		.miso_oe(miso_oe),
		.pd_i(pd_q),
		.rd_data_i(rd_q),
		.ev_o(ev_link),
		.ev_tgl_o(link_ev_tgl),
		.rdc_tgl_o(link_rdc_tgl)
	);

	// ==========================================
	// Crossings into the core clock
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{ev_s1_q, ev_s2_q, ev_s3_q} <= 3'h0;
			{rc_s1_q, rc_s2_q, rc_s3_q} <= 3'h0;
			{ce_s1_q, ce_s2_q, ce_s3_q} <= 3'h0;
			{lf_s1_q, lf_s2_q, lf_s3_q} <= 3'h0;
		end
		else
		begin
			{ev_s1_q, ev_s2_q, ev_s3_q} <= {link_ev_tgl, ev_s1_q, ev_s2_q};
			{rc_s1_q, rc_s2_q, rc_s3_q} <= {link_rdc_tgl, rc_s1_q, rc_s2_q};
			{ce_s1_q, ce_s2_q, ce_s3_q} <= {ce_in, ce_s1_q, ce_s2_q};
			{lf_s1_q, lf_s2_q, lf_s3_q} <= {line_fail_in, lf_s1_q, lf_s2_q};
		end
	end

	// Event word is stable long before its toggle lands here
	wire ev_p = ev_s2_q ^ ev_s3_q;
	wire rdc_p = (rc_s2_q ^ rc_s3_q) & ~pd_q;
	wire ce_rise = ce_s2_q & ~ce_s3_q;
	wire fail_rise = lf_s2_q & ~lf_s3_q;

	// ==========================================
	// Register decode
	wire ev_wr = evv_q & ev_q.write & ~ev_q.is_addr & ~pd_q;
	wire [7:0] ev_off = {2'b00, ev_q.loc};
	wire [7:0] rd_off = {2'b00, rd_loc_q};
	wire wr_tbc = ev_wr & (ev_off == OFF_TIMEBASE_CONTROL);
	wire wr_irqc = ev_wr & (ev_off == OFF_IRQ_CONTROL);
	wire rtcs_irqc_t irqc_new = rtcs_irqc_t'(ev_q.data);
	wire st_rd = rdc_p & (rd_off == OFF_EVENT_FLAGS);
	wire [7:0] flags_w = {1'b0, st_wd_q, 1'b0, st_ftu_q,
		st_int_q, st_ps_q, st_al_q, st_per_q};
	wire [7:0] rd_mux = (rd_off == OFF_EVENT_FLAGS) ? flags_w :
		(rd_off == OFF_TIMEBASE_CONTROL) ? tbc_q :
		(rd_off == OFF_IRQ_CONTROL) ? irqc_q : RD_UNMAPPED;
	wire [5:0] next_loc = ev_q.is_addr ? ev_q.loc :
		{ev_q.loc[5], ev_q.loc[4:0] + 5'h01};

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ev_q <= '0;
			evv_q <= 1'b0;
			rd_loc_q <= 6'h00;
			rd_q <= RD_UNMAPPED;
		end
		else
		begin
			evv_q <= ev_p;
			if (ev_p)
				ev_q <= ev_link;
			if (evv_q)
				rd_loc_q <= next_loc;
			rd_q <= rd_mux;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tbc_q <= rtcs_tbc_t'(TBC_RST);
			irqc_q <= rtcs_irqc_t'(IRQC_RST);
		end
		else
		begin
			if (wr_tbc)
				tbc_q <= rtcs_tbc_t'(ev_q.data);
			if (wr_irqc)
				irqc_q <= irqc_new;
		end
	end

	// ==========================================
	// Interrupt sources
	wire [15:0] tick_vec = {rate_tick_in, 1'b0};
	// Code 6 tick is 64 Hz on crystal or mains rate on line
	wire per_ev = (irqc_q.per != PER_OFF) & tick_vec[irqc_q.per];
	wire al_ev = irqc_q.alarm & alarm_match_in & ~al_prev_q;
	wire ps_ev = irqc_q.psense & ps_armed_q & fail_rise;
	wire any_ev = per_ev | al_ev | ps_ev;
	wire ps_arm = wr_irqc & irqc_new.psense & ~irqc_q.psense;
	wire ps_disarm = wr_irqc & ~irqc_new.psense;
	wire wr_pd = wr_irqc & irqc_new.pdown;
	wire wd_last = (wd_cnt_q == WDW'(WDOG_CYCLES - 1));
	wire wd_to = irqc_q.wdog & ~ce_rise & wd_last;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			al_prev_q <= 1'b0;
			ps_armed_q <= 1'b0;
		end
		else
		begin
			al_prev_q <= alarm_match_in;
			// Rearm only on a zero-to-one write
			if (ps_arm)
				ps_armed_q <= 1'b1;
			else if (ps_ev || ps_disarm)
				ps_armed_q <= 1'b0;
		end
	end

	// ==========================================
	// Event flags; a set in the clearing cycle wins
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{st_wd_q, st_int_q, st_ps_q, st_al_q, st_per_q} <= 5'h00;
			st_ftu_q <= 1'b1;
			irq_pend_q <= 1'b0;
		end
		else
		begin
			st_wd_q <= (st_wd_q & ~st_rd) | wd_to;
			st_ftu_q <= st_ftu_q & ~st_rd;
			st_int_q <= (st_int_q & ~st_rd) | any_ev;
			st_ps_q <= st_ps_q | ps_ev;
			st_al_q <= (st_al_q & ~st_rd) | al_ev;
			st_per_q <= (st_per_q & ~st_rd) | per_ev;
			irq_pend_q <= (irq_pend_q & ~st_rd) | any_ev;
		end
	end

	// ==========================================
	// Watchdog and host reset
	// Any chip-enable rise restarts the count, framed or bare;
	// a frame longer than the window still times out

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wd_cnt_q <= '0;
			hrst_cnt_q <= '0;
		end
		else
		begin
			if (!irqc_q.wdog || ce_rise || wd_last)
				wd_cnt_q <= '0;
			else
				wd_cnt_q <= wd_cnt_q + WDW'(1);
			if (wd_to)
				hrst_cnt_q <= HRW'(HRST_CYC);
			else if (hrst_cnt_q != '0)
				hrst_cnt_q <= hrst_cnt_q - HRW'(1);
		end
	end

	// ==========================================
	// Power-down; a request beats a wake in the same cycle
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			pd_q <= 1'b0;
		else if (wr_pd)
			pd_q <= 1'b1;
		else if (any_ev)
			pd_q <= 1'b0;
	end

	// ==========================================
	// Pin outputs
	wire hrst_act = pd_q | (hrst_cnt_q != '0);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sqw_out <= 1'b0;
			supply_enable_out <= 1'b1;
			host_reset_out_n <= 1'b1;
			host_reset_oe <= 1'b0;
			irq_n <= 1'b1;
			irq_oe <= 1'b0;
			tbc_o <= rtcs_tbc_t'(TBC_RST);
		end
		else
		begin
			sqw_out <= ~pd_q & (tbc_q.sqw != SQW_OFF) & sqw_src_in[tbc_q.sqw];
			supply_enable_out <= ~pd_q;
			host_reset_out_n <= ~hrst_act;
			host_reset_oe <= hrst_act;
			irq_n <= ~irq_pend_q;
			irq_oe <= irq_pend_q;
			tbc_o <= tbc_q;
			tbc_o.line <= tbc_q.line & ~irqc_q.psense;
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	wdog_off_a: assert property (!irqc_q.wdog |=> wd_cnt_q == '0)
		else $error("watchdog counts while disabled");
	wdog_fire_a: assert property (wd_to |=> st_wd_q ##1 !host_reset_out_n)
		else $error("watchdog timeout without reset and flag");
	pdown_pins_a: assert property (pd_q |=> !supply_enable_out && !sqw_out
		&& host_reset_oe)
		else $error("power-down pins not forced");
	tbc_write_a: assert property (wr_tbc |=> tbc_q == $past(ev_q.data))
		else $error("timebase control write lost");
	psense_flag_a: assert property (ps_ev |=> st_ps_q && st_int_q ##1 !irq_n)
		else $error("power-sense event not flagged");
	alarm_irq_a: assert property (al_ev |-> ##2 irq_oe)
		else $error("alarm did not raise interrupt");
	read_clear_a: assert property (st_rd && !any_ev && !wd_to |=> !st_al_q
		&& !st_per_q && !st_ftu_q && st_ps_q == $past(st_ps_q))
		else $error("flag read clear wrong");
	irq_hold_a: assert property (irq_pend_q && !st_rd |=> irq_pend_q)
		else $error("interrupt dropped before flag read");
	pd_wake_a: assert property (pd_q && any_ev && !wr_pd |=> !pd_q ##1
		supply_enable_out)
		else $error("interrupt did not end power-down");
	per_flag_a: assert property (per_ev |=> st_per_q && st_int_q)
		else $error("periodic event not flagged");
	alarm_flag_a: assert property (al_ev |=> st_al_q && st_int_q)
		else $error("alarm event not flagged");
	psense_once_a: assert property (ps_ev && !ps_arm |=> !ps_armed_q)
		else $error("power sense stayed armed");
	line_cut_a: assert property (irqc_q.psense |=> !tbc_o.line)
		else $error("line source not cut by power sense");
	irqc_write_a: assert property (wr_irqc |=> irqc_q == $past(irqc_new))
		else $error("interrupt control write lost");
	irq_pins_a: assert property (irq_pend_q |=> !irq_n && irq_oe)
		else $error("interrupt pin not driven while pending");
	hrst_pulse_a: assert property (hrst_cnt_q != '0 |=> !host_reset_out_n && host_reset_oe)
		else $error("host reset pulse not driven");
	ftu_kept_a: assert property (!st_ftu_q |=> !st_ftu_q)
		else $error("first-up flag set outside reset");
endmodule : rtcs_core
`default_nettype wire

// File: tb/rtcs_host_model.sv
/*
 Host serial master model: frames with chip enable, either idle polarity,
 one byte of address/control then one data byte, MSB first.
 Assumes the device launches on the edge leaving idle.
*/
`timescale 1ns/1ns
`default_nettype none
module rtcs_host_model (
	// Link pins
	output logic sck,
	output logic ce,
	output logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	// ==========================================
	// Frame state
	logic cpol;
	logic oe_seen;
	initial
	begin
		cpol = 1'b0;
		oe_seen = 1'b0;
		sck = 1'b0;
		ce = 1'b0;
		mosi = 1'b0;
	end
	// ==========================================
	// One 16-bit frame, 125 ns per bit
	task automatic xfer(input logic [7:0] acb, input logic [7:0] wd, output logic [7:0] rd);
		logic [15:0] sh;
		sh = {acb, wd};
		oe_seen = 1'b0;
		rd = 8'h00;
		sck = cpol;
		#100 ce = 1'b1;
		#60;
		for (int i = 15; i >= 0; i--)
		begin
			sck = ~cpol;
			mosi = sh[i];
			#62;
			oe_seen = oe_seen | miso_oe;
			if (i < 8)
				rd = {rd[6:0], miso};
			sck = cpol;
			#63;
		end
		ce = 1'b0;
		// Released line shows no stale value
		mosi = ~mosi;
	endtask : xfer
	// Bare chip-enable pulse, clock standing still
	task automatic ce_pulse;
		#100 ce = 1'b1;
		#200 ce = 1'b0;
	endtask : ce_pulse
endmodule : rtcs_host_model
`default_nettype wire

// File: tb/rtcs_core_tb.sv
/*
 Self-checking bench for the clock control block and its serial port.
 Assumes the host model in the same folder and a shortened watchdog.
*/
`timescale 1ns/1ns
`default_nettype none
module rtcs_core_tb;
	import rtcs_pkg::*;
	// ==========================================
	// Signals
	localparam int WDC = 400;
	logic core_clk = 1'b0;
	logic rst_n;
	logic [15:1] rate_tick_in;
	logic alarm_match_in;
	logic line_fail_in;
	logic [7:0] sqw_src_in;
	wire sck;
	wire ce;
	wire mosi;
	logic miso_o;
	logic miso_oe;
	wire miso_w;
	rtcs_tbc_t tbc_o;
	logic sqw_out;
	logic supply_enable_out;
	logic host_reset_out_n;
	logic host_reset_oe;
	logic irq_n;
	logic irq_oe;
	int failures = 0;
	int checks_done = 0;
	int cyc = 0;
	logic [7:0] d;
	// No pull on the data out line: show the inverse when released
	assign miso_w = miso_oe ? miso_o : ~miso_o;
	always #5 core_clk = ~core_clk;
	// ==========================================
	// Instances
	rtcs_core #(.WDOG_CYCLES(WDC)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
		.sck_in(sck), .ce_in(ce), .mosi_in(mosi), .miso_o(miso_o), .miso_oe(miso_oe),
		.rate_tick_in(rate_tick_in), .alarm_match_in(alarm_match_in),
		.line_fail_in(line_fail_in), .sqw_src_in(sqw_src_in), .tbc_o(tbc_o),
		.sqw_out(sqw_out), .supply_enable_out(supply_enable_out),
		.host_reset_out_n(host_reset_out_n), .host_reset_oe(host_reset_oe),
		.irq_n(irq_n), .irq_oe(irq_oe));
	rtcs_host_model u_host (.sck(sck), .ce(ce), .mosi(mosi), .miso(miso_w),
		.miso_oe(miso_oe));
	// ==========================================
	// Shared tasks
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wait_n(input int n);
		repeat (n) @(posedge core_clk);
	endtask : wait_n
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] got;
		u_host.xfer(a, 8'h00, got);
		wait_n(8);
		chk("read data", exp, got);
		chk("miso_oe idle", 8'h00, {7'h0, miso_oe});
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		u_host.xfer(a | 8'h80, v, d);
		wait_n(8);
		chk("miso_oe in write", 8'h00, {7'h0, u_host.oe_seen});
	endtask : wr
	task automatic tick(input int code);
		@(posedge core_clk);
		rate_tick_in[code] <= 1'b1;
		@(posedge core_clk);
		rate_tick_in <= '0;
		wait_n(6);
	endtask : tick
	task automatic do_reset;
		@(posedge core_clk);
		rst_n <= 1'b0;
		wait_n(4);
		rst_n <= 1'b1;
		wait_n(4);
	endtask : do_reset
	task automatic results;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	// ==========================================
	// Scenarios
	task automatic t_reset;
		chk("supply enable", 8'h01, {7'h0, supply_enable_out});
		chk("host reset oe", 8'h00, {7'h0, host_reset_oe});
		chk("host reset pin", 8'h01, {7'h0, host_reset_out_n});
		rd(8'h31, TBC_RST);
		rd(8'h32, IRQC_RST);
		rd(8'h30, 8'h10);
		rd(8'h30, 8'h00);
		rd(8'h3f, RD_UNMAPPED);
	endtask : t_reset
	task automatic t_timebase;
		u_host.cpol = 1'b1;
		wr(8'h31, 8'ha5);
		chk("tbc_o", 8'ha5, tbc_o);
		rd(8'h31, 8'ha5);
		u_host.cpol = 1'b0;
		chk("sqw_out", 8'h01, {7'h0, sqw_out});
	endtask : t_timebase
	task automatic t_periodic;
		for (int c = 0; c < 16; c++)
		begin
			wr(8'h32, c[7:0]);
			tick((c % 15) + 1);
			chk("irq wrong rate", 8'h00, {7'h0, irq_oe});
			if (c > 0)
				tick(c);
			chk("irq periodic", (c > 0) ? 8'h01 : 8'h00, {7'h0, irq_oe});
			rd(8'h30, (c > 0) ? 8'h09 : 8'h00);
			chk("irq after read", 8'h00, {7'h0, irq_oe});
		end
	endtask : t_periodic
	task automatic t_alarm;
		for (int e = 0; e < 2; e++)
		begin
			wr(8'h32, e ? 8'h10 : 8'h00);
			@(posedge core_clk);
			alarm_match_in <= 1'b1;
			wait_n(20);
			alarm_match_in <= 1'b0;
			chk("irq_n alarm", e ? 8'h00 : 8'h01, {7'h0, irq_n});
			rd(8'h30, e ? 8'h0a : 8'h00);
		end
	endtask : t_alarm
	task automatic t_pdown;
		wr(8'h32, 8'h43);
		chk("pd supply", 8'h00, {7'h0, supply_enable_out});
		chk("pd host reset", 8'h01, {7'h0, host_reset_oe});
		chk("pd sqw", 8'h00, {7'h0, sqw_out});
		chk("pd host pin", 8'h00, {7'h0, host_reset_out_n});
		u_host.xfer(8'h31, 8'h00, d);
		chk("pd port off", 8'h00, {7'h0, u_host.oe_seen});
		tick(3);
		chk("wake supply", 8'h01, {7'h0, supply_enable_out});
		chk("wake host reset", 8'h00, {7'h0, host_reset_oe});
		rd(8'h30, 8'h09);
		wr(8'h32, 8'h00);
	endtask : t_pdown
	task automatic t_wdog;
		int n;
		wr(8'h32, 8'h80);
		repeat (5)
		begin
			wait_n(WDC / 2);
			u_host.ce_pulse();
			chk("wdog kept", 8'h00, {7'h0, host_reset_oe});
		end
		n = 0;
		while (host_reset_oe !== 1'b1 && n < 2 * WDC)
		begin
			@(posedge core_clk);
			n++;
		end
		chk("wdog fired", 8'h01, {7'h0, host_reset_oe});
		chk("wdog host pin", 8'h00, {7'h0, host_reset_out_n});
		wait_n(HRST_CYC + 10);
		chk("wdog reset end", 8'h01, {7'h0, host_reset_out_n});
		rd(8'h30, 8'h40);
		wr(8'h32, 8'h00);
	endtask : t_wdog
	task automatic line_event(input logic [7:0] exp);
		@(posedge core_clk);
		line_fail_in <= 1'b1;
		wait_n(10);
		line_fail_in <= 1'b0;
		wait_n(10);
		chk("irq sense", exp, {7'h0, irq_oe});
	endtask : line_event
	task automatic t_psense;
		wr(8'h31, 8'h40);
		chk("tbc_o line", 8'h40, tbc_o);
		wr(8'h32, 8'h20);
		chk("line cut", 8'h00, {7'h0, tbc_o.line});
		line_event(8'h01);
		rd(8'h30, 8'h0c);
		rd(8'h30, 8'h04);
		line_event(8'h00);
		wr(8'h32, 8'h00);
		wr(8'h32, 8'h20);
		line_event(8'h01);
		do_reset();
		rd(8'h30, 8'h10);
	endtask : t_psense
	// ==========================================
	// Main sequence and timeout
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 80000)
		begin
			failures++;
			results();
		end
	end
	initial
	begin
		rst_n = 1'b0;
		rate_tick_in = '0;
		alarm_match_in = 1'b0;
		line_fail_in = 1'b0;
		sqw_src_in = 8'h20;
		wait_n(4);
		rst_n <= 1'b1;
		wait_n(4);
		t_reset();
		t_timebase();
		t_periodic();
		t_alarm();
		t_pdown();
		t_wdog();
		t_psense();
		results();
	end
endmodule : rtcs_core_tb
`default_nettype wire
